// ===== core/arp_core.sv
//
// Overview of operation
// - Reset held low: converter reset, zero output code
// - Reset clears modulator, comparator pattern 0011
// - Reset clears filter, buffers; registers load reset values
// - During reset: writes ignored, ready pulse and serial data outputs high-impedance
// - Delay setting: 12-bit signed, modulator periods
// - Applied delay is setting plus half ratio
// - Delay limited to zero through ratio minus one
// - Sign bit position follows the oversampling ratio
// - Any delay write restarts the converter
// - Ready flag read-only, resets to one
// - Output refresh drives ready flag to zero
// - Status read returns ready flag to one unless a refresh falls in the same cycle
// - Select low: internal oscillator, serial-peripheral mode only
// - Select high: clock pin, second pin sets interface
// - Output is (raw plus offset) times (1+gain), raw in two-wire mode
// - Offset added without latency, significant bits only
// - No offset in reset/shutdown; value kept in shutdown, reset clears it
// - Gain value signed, LSB weighs 2^-23
// - Gain enable adds 24 modulator periods latency, none in two-wire mode
// - No gain in reset/shutdown; value kept in shutdown, reset clears it
// - Overflow saturates to full-scale codes
// - Ready pulse output marks each new result
//
`timescale 1ns/10ps
module arp_core (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ext_clk_pin,
   input  wire logic        oscillator_pin_two,
   input  wire logic        shutdown,
   input  wire logic [3:0]  mod_bits,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [23:0] reg_wdata,
   input  wire logic        sdo_data,
   input  wire logic        sdo_drive,
   output logic [23:0]      reg_rdata,
   output logic [23:0]      data_code,
   output logic [3:0]       mod_pattern,
   output logic             ready_pulse_n,
   output logic             ready_pulse_oe_n,
   output logic             sdo,
   output logic             sdo_oe_n
);

   typedef struct packed {
      logic [11:0] phase;
      logic [23:0] offset;
      logic [23:0] gain;
      logic [7:0]  cfg;
      logic        fmt24;
      logic        ready_n;
      logic [23:0] rdata;
      logic [3:0]  pattern;
      logic [16:0] acc;
      logic [23:0] hold0;
      logic [23:0] hold1;
      logic [23:0] dout;
      logic [11:0] pos;
      logic [4:0]  lat;
      logic        lat_run;
      logic        drp_n;
      logic        drp_oe_n;
      logic        sdo;
      logic        sdo_oe_n;
   } arp_core_t;

   arp_core_t   r;
   arp_core_t   next_r;

   logic        mod_tick;
   logic        two_wire;
   logic [2:0]  osr_sel;
   logic [11:0] osr_last;
   logic [11:0] delay;
   logic [23:0] raw;
   logic [3:0]  shamt;
   logic [23:0] corr_code;
   logic        sample;
   logic        refresh;
   logic        restart;
   logic        active;

   // ----------------------------------------
   // Clock source, prescaler, interface mode
   // ----------------------------------------
   arp_clk_gen arp_clk_gen_inst (
      .ref_clk               (ref_clk),
      .rst_n                 (rst_n),
      .ext_clk_pin           (ext_clk_pin),
      .oscillator_pin_two    (oscillator_pin_two),
      .external_clock_select (r.cfg[arp_pkg::CFG_EXTCLK]),
      .prescale              (r.cfg[arp_pkg::CFG_PRE +: 2]),
      .mod_tick              (mod_tick),
      .two_wire              (two_wire)
   );

   // ----------------------------------------
   // Offset and gain correction
   // ----------------------------------------
   arp_correct arp_correct_inst (
      .raw               (r.hold0),
      .offset_cal_value  (r.offset),
      .gain_cal_value    (r.gain),
      .offset_cal_enable (r.cfg[arp_pkg::CFG_OFFEN]),
      .gain_cal_enable   (r.cfg[arp_pkg::CFG_GAINEN]),
      .bypass            (two_wire | shutdown),
      .osr_sel           (osr_sel),
      .fmt24             (r.fmt24),
      .code              (corr_code)
   );

   // ----------------------------------------
   // Phase delay decode
   // ----------------------------------------
   always_comb
   begin
      osr_sel  = r.cfg[arp_pkg::CFG_OSR +: 3];
      osr_last = 12'((arp_pkg::OSR_MIN << osr_sel) - 13'h0001);
      // Sign bit sits at 4 plus ratio select
      // Inverting it adds half the ratio
      // Bits above the sign bit dropped, range 0..ratio-1
      delay = 12'h000;
      for (int i = 0; i < 12; i++)
      begin
         if (i < 4 + int'(osr_sel))
            delay[i] = r.phase[i];
         else if (i == 4 + int'(osr_sel))
            delay[i] = ~r.phase[i];
      end
      shamt = 4'hf - {1'b0, osr_sel};
      raw   = 24'({{7{r.acc[16]}}, r.acc} << shamt);
   end

   // ----------------------------------------
   // Conversion, registers and outputs
   // ----------------------------------------
   always_comb
   begin
      next_r  = r;
      active  = !shutdown;
      restart = reg_wr && reg_addr == arp_pkg::ADR_PHASE;
      sample  = mod_tick && active && r.pos == delay;
      refresh = 1'b0;

      // Modulator pattern and decimator
      if (mod_tick && active)
      begin
         next_r.pattern = mod_bits;
         next_r.pos = (r.pos == osr_last) ? 12'h000 : r.pos + 12'h001;
         if (sample)
            next_r.acc = {{13{r.pattern[3]}}, r.pattern};
         else
            next_r.acc = r.acc + {{13{r.pattern[3]}}, r.pattern};
      end

      // Result capture and gain latency
      if (sample)
      begin
         next_r.hold0 = raw;
         if (r.cfg[arp_pkg::CFG_GAINEN] && !two_wire)
         begin
            next_r.lat_run = 1'b1;
            next_r.lat     = arp_pkg::GAIN_LAT;
         end
         else
            refresh = 1'b1;
      end
      else if (r.lat_run && mod_tick)
      begin
         next_r.lat = r.lat - 5'h01;
         if (r.lat == 5'h01)
         begin
            next_r.lat_run = 1'b0;
            refresh = 1'b1;
         end
      end

      // Restart cancels a result due in the same cycle
      if (restart)
         refresh = 1'b0;

      // Ready pulse lasts one modulator period
      if (mod_tick)
         next_r.drp_n = 1'b1;
      if (refresh)
      begin
         next_r.hold1 = r.hold0;
         next_r.dout  = corr_code;
         next_r.drp_n = 1'b0;
      end
      next_r.drp_oe_n = 1'b0;

      // Register reads
      if (reg_rd)
      begin
         case (reg_addr)
            arp_pkg::ADR_DATA:   next_r.rdata = r.dout;
            arp_pkg::ADR_STATUS: next_r.rdata = {22'h0, r.fmt24,
                                                r.ready_n};
            arp_pkg::ADR_CONFIG: next_r.rdata = {16'h0000, r.cfg};
            arp_pkg::ADR_PHASE:  next_r.rdata = {12'h000, r.phase};
            arp_pkg::ADR_OFFSET: next_r.rdata = r.offset;
            arp_pkg::ADR_GAIN:   next_r.rdata = r.gain;
            default:             next_r.rdata = 24'h000000;
         endcase
         if (reg_addr == arp_pkg::ADR_STATUS)
            next_r.ready_n = 1'b1;
      end

      // Register writes; ready flag has no write path
      if (reg_wr)
      begin
         case (reg_addr)
            arp_pkg::ADR_STATUS:
               next_r.fmt24 = reg_wdata[arp_pkg::ST_FMT24];
            arp_pkg::ADR_CONFIG:
            begin
               next_r.cfg = reg_wdata[7:0];
               // Enable bits leave stored values alone
               if (two_wire)
                  next_r.cfg[arp_pkg::CFG_EXTCLK] = 1'b1;
            end
            arp_pkg::ADR_PHASE:  next_r.phase  = reg_wdata[11:0];
            arp_pkg::ADR_OFFSET: next_r.offset = reg_wdata;
            arp_pkg::ADR_GAIN:   next_r.gain   = reg_wdata;
            default:             next_r.phase  = r.phase;
         endcase
      end

      // Phase write restarts the converter
      if (restart)
      begin
         next_r.pos     = 12'h000;
         next_r.acc     = 17'h00000;
         next_r.hold0   = arp_pkg::ZERO_CODE;
         next_r.lat     = 5'h00;
         next_r.lat_run = 1'b0;
         refresh        = 1'b0;
      end

      // Refresh wins over a status read
      if (refresh)
         next_r.ready_n = 1'b0;

      // Serial data output driven from the serial engine
      next_r.sdo      = sdo_data;
      next_r.sdo_oe_n = ~sdo_drive;

      // Hard reset
      if (!rst_n)
      begin
         next_r.phase    = arp_pkg::RST_PHASE;
         next_r.offset   = arp_pkg::RST_OFFSET;
         next_r.gain     = arp_pkg::RST_GAIN;
         next_r.cfg      = arp_pkg::RST_CONFIG;
         next_r.fmt24    = arp_pkg::RST_FMT24;
         next_r.ready_n  = arp_pkg::RST_READY;
         next_r.rdata    = 24'h000000;
         next_r.pattern  = arp_pkg::COMP_RESET;
         next_r.acc      = 17'h00000;
         next_r.hold0    = arp_pkg::ZERO_CODE;
         next_r.hold1    = arp_pkg::ZERO_CODE;
         next_r.dout     = arp_pkg::ZERO_CODE;
         next_r.pos      = 12'h000;
         next_r.lat      = 5'h00;
         next_r.lat_run  = 1'b0;
         next_r.drp_n    = 1'b1;
         next_r.drp_oe_n = 1'b1;
         next_r.sdo      = 1'b0;
         next_r.sdo_oe_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      r <= next_r;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata        = r.rdata;
   assign data_code        = r.dout;
   assign mod_pattern      = r.pattern;
   assign ready_pulse_n    = r.drp_n;
   assign ready_pulse_oe_n = r.drp_oe_n;
   assign sdo              = r.sdo;
   assign sdo_oe_n         = r.sdo_oe_n;

endmodule : arp_core

// ===== pkg/arp_pkg.sv
package arp_pkg;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [4:0]  ADR_DATA   = 5'h00;
   localparam logic [4:0]  ADR_STATUS = 5'h01;
   localparam logic [4:0]  ADR_CONFIG = 5'h02;
   localparam logic [4:0]  ADR_PHASE  = 5'h03;
   localparam logic [4:0]  ADR_OFFSET = 5'h04;
   localparam logic [4:0]  ADR_GAIN   = 5'h05;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int          ST_READY   = 0;
   localparam int          ST_FMT24   = 1;
   localparam int          CFG_OSR    = 0;
   localparam int          CFG_PRE    = 3;
   localparam int          CFG_OFFEN  = 5;
   localparam int          CFG_GAINEN = 6;
   localparam int          CFG_EXTCLK = 7;

   // ----------------------------------------
   // Values after reset
   // ----------------------------------------
   localparam logic [11:0] RST_PHASE  = 12'h000;
   localparam logic [23:0] RST_OFFSET = 24'h000000;
   localparam logic [23:0] RST_GAIN   = 24'h000000;
   localparam logic [7:0]  RST_CONFIG = 8'h03;
   localparam logic        RST_FMT24  = 1'b1;
   localparam logic        RST_READY  = 1'b1;
   localparam logic [23:0] ZERO_CODE  = 24'h000000;
   localparam logic [3:0]  COMP_RESET = 4'h3;

   // ----------------------------------------
   // Counts and limits
   // ----------------------------------------
   localparam logic [4:0]  GAIN_LAT   = 5'h18;
   localparam logic [3:0]  OSC_DIV    = 4'h4;
   localparam int          MCLK_MAX_MHZ = 20;
   localparam logic [12:0] OSR_MIN    = 13'h0020;
   localparam logic [25:0] GAIN_ONE   = 26'h0800000;
   localparam logic [23:0] SAT24_HI   = 24'h7fffff;
   localparam logic [23:0] SAT24_LO   = 24'h800000;
   localparam logic [23:0] SAT16_HI   = 24'h7fff00;
   localparam logic [23:0] SAT16_LO   = 24'h800000;

endpackage : arp_pkg

// ===== core/arp_clk_gen.sv
`timescale 1ns/10ps
module arp_clk_gen (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ext_clk_pin,
   input  wire logic       oscillator_pin_two,
   input  wire logic       external_clock_select,
   input  wire logic [1:0] prescale,
   output logic            mod_tick,
   output logic            two_wire
);

   typedef struct packed {
      logic [1:0] ext_sync;
      logic       ext_prev;
      logic [1:0] oscillator_pin_two_sync;
      logic [3:0] osc_cnt;
      logic [2:0] pre_cnt;
      logic       tick;
      logic       two_wire;
   } arp_clk_t;

   arp_clk_t r;
   arp_clk_t next_r;
   logic     mclk_tick;
   logic [2:0] pre_mask;

   // ----------------------------------------
   // Master clock source and prescaler
   // ----------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.ext_sync  = {r.ext_sync[0], ext_clk_pin};
      next_r.ext_prev  = r.ext_sync[1];
      next_r.oscillator_pin_two_sync = {r.oscillator_pin_two_sync[0], oscillator_pin_two};
      // Internal oscillator only when external select is low
      if (r.osc_cnt == OSC_DIV_M1())
         next_r.osc_cnt = 4'h0;
      else
         next_r.osc_cnt = r.osc_cnt + 4'h1;
      // Bypass to the clock pin, second pin picks interface
      if (external_clock_select)
         mclk_tick = r.ext_sync[1] & ~r.ext_prev;
      else
         mclk_tick = (r.osc_cnt == OSC_DIV_M1());
      next_r.two_wire = external_clock_select & r.oscillator_pin_two_sync[1];
      pre_mask = 3'((4'h1 << prescale) - 4'h1);
      next_r.tick = 1'b0;
      if (mclk_tick)
      begin
         next_r.pre_cnt = r.pre_cnt + 3'h1;
         next_r.tick = ((r.pre_cnt & pre_mask) == pre_mask);
      end
      if (!rst_n)
      begin
         next_r.osc_cnt  = 4'h0;
         next_r.pre_cnt  = 3'h0;
         next_r.tick     = 1'b0;
         next_r.two_wire = 1'b0;
      end
   end

   function automatic logic [3:0] OSC_DIV_M1();
      return arp_pkg::OSC_DIV - 4'h1;
   endfunction : OSC_DIV_M1

   always_ff @(posedge ref_clk)
   begin
      r <= next_r;
   end

   assign mod_tick = r.tick;
   assign two_wire = r.two_wire;

endmodule : arp_clk_gen

// ===== core/arp_correct.sv
`timescale 1ns/10ps
module arp_correct (
   input  wire logic [23:0] raw,
   input  wire logic [23:0] offset_cal_value,
   input  wire logic [23:0] gain_cal_value,
   input  wire logic        offset_cal_enable,
   input  wire logic        gain_cal_enable,
   input  wire logic        bypass,
   input  wire logic [2:0]  osr_sel,
   input  wire logic        fmt24,
   output logic [23:0]      code
);

   logic [23:0]        off_mask;
   logic [23:0]        off_m;
   logic signed [24:0] sum;
   logic signed [25:0] mult;
   logic signed [50:0] prod;
   logic signed [27:0] full;

   // ----------------------------------------
   // Offset, gain and saturation
   // ----------------------------------------
   always_comb
   begin
      // Only the significant bits at low ratios
      case (osr_sel)
         3'h0:    off_mask = 24'hffff80;
         3'h1:    off_mask = 24'hfffff0;
         3'h2:    off_mask = 24'hfffffe;
         default: off_mask = 24'hffffff;
      endcase
      off_m = offset_cal_value & off_mask;
      if (!offset_cal_enable || bypass)
         off_m = 24'h000000;
      sum  = {raw[23], raw} + {off_m[23], off_m};
      mult = arp_pkg::GAIN_ONE + {{2{gain_cal_value[23]}}, gain_cal_value};
      prod = sum * mult;
      if (gain_cal_enable && !bypass)
         full = prod[50:23];
      else
         full = {{3{sum[24]}}, sum};
      // Clamp to full scale on overflow
      if (full > 28'sh07fffff)
         code = fmt24 ? arp_pkg::SAT24_HI : arp_pkg::SAT16_HI;
      else if (full < -28'sh0800000)
         code = fmt24 ? arp_pkg::SAT24_LO : arp_pkg::SAT16_LO;
      else if (fmt24)
         code = full[23:0];
      else
         code = {full[23:8], 8'h00};
   end

endmodule : arp_correct

// ===== verif/arp_core_properties.sv
`timescale 1ns/10ps
module arp_core_properties (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ext_clk_pin,
   input  wire logic        oscillator_pin_two,
   input  wire logic        shutdown,
   input  wire logic [3:0]  mod_bits,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [23:0] reg_wdata,
   input  wire logic        sdo_data,
   input  wire logic        sdo_drive,
   input  wire logic [23:0] reg_rdata,
   input  wire logic [23:0] data_code,
   input  wire logic [3:0]  mod_pattern,
   input  wire logic        ready_pulse_n,
   input  wire logic        ready_pulse_oe_n,
   input  wire logic        sdo,
   input  wire logic        sdo_oe_n
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic rd_st;
   assign rd_st = rst_n && reg_rd && (reg_addr == arp_pkg::ADR_STATUS);

   default clocking cb @(posedge ref_clk);
   endclocking

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_rst_zero: assert property (!rst_n |=> data_code == 24'h000000)
      else $error("data code not zero in reset");
   a_rst_comp: assert property (
      !rst_n |=> mod_pattern == arp_pkg::COMP_RESET)
      else $error("comparator pattern wrong in reset");
   a_rst_clear: assert property (!rst_n |=> reg_rdata == 24'h000000)
      else $error("read data not cleared in reset");
   a_rst_hiz: assert property (
      !rst_n |=> ready_pulse_oe_n && sdo_oe_n && ready_pulse_n)
      else $error("outputs driven in reset");
   a_oe_drive: assert property (rst_n |=> !ready_pulse_oe_n)
      else $error("ready pulse not driven after reset");
   a_sdo_follow: assert property (rst_n |=>
      sdo == $past(sdo_data) && sdo_oe_n == !$past(sdo_drive))
      else $error("serial output does not follow request");
   a_code_pulse: assert property (disable iff (!rst_n)
      $changed(data_code) |-> $fell(ready_pulse_n))
      else $error("code changed without ready pulse");
   a_pulse_low: assert property (disable iff (!rst_n)
      $fell(ready_pulse_n) |-> !ready_pulse_n [*3])
      else $error("ready pulse too short");
   a_status_clr: assert property (disable iff (!rst_n)
      rd_st ##1 (rd_st && !$fell(ready_pulse_n)) |=> reg_rdata[0])
      else $error("status read did not clear ready flag");
endmodule : arp_core_properties

bind arp_core arp_core_properties arp_core_properties_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .ext_clk_pin(ext_clk_pin),
   .oscillator_pin_two(oscillator_pin_two), .shutdown(shutdown),
   .mod_bits(mod_bits), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sdo_data(sdo_data),
   .sdo_drive(sdo_drive), .reg_rdata(reg_rdata), .data_code(data_code),
   .mod_pattern(mod_pattern), .ready_pulse_n(ready_pulse_n),
   .ready_pulse_oe_n(ready_pulse_oe_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

// ===== verif/arp_host_model.sv
`timescale 1ns/10ps
module arp_host_model (
   input  wire logic       ext_run,
   input  wire logic       mode_req,
   input  wire logic [3:0] mod_level,
   output logic            ext_clk_pin,
   output logic            oscillator_pin_two,
   output logic [3:0]      mod_bits
);
   // ----------------------------------------
   // External master clock, 12.5 MHz
   // ----------------------------------------
   initial ext_clk_pin = 1'b0;
   always #40 ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;

   // Mode pin falls low unless driven high
   assign oscillator_pin_two = (mode_req === 1'b1);
   assign mod_bits = mod_level;
endmodule : arp_host_model

// ===== verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic        ref_clk, rst_n, shutdown, reg_wr, reg_rd;
   logic        ext_clk_pin, oscillator_pin_two, ext_run, mode_req;
   logic        sdo_data, sdo_drive, sdo, sdo_oe_n;
   logic        ready_pulse_n, ready_pulse_oe_n;
   logic [3:0]  mod_bits, mod_level, mod_pattern;
   logic [4:0]  reg_addr;
   logic [23:0] reg_wdata, reg_rdata, data_code, q;
   int          error_cnt = 0, n_tests = 0, cyc = 0, n0, n1, n2;

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   arp_core arp_core_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .ext_clk_pin(ext_clk_pin), .oscillator_pin_two(oscillator_pin_two),
      .shutdown(shutdown), .mod_bits(mod_bits), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .sdo_data(sdo_data), .sdo_drive(sdo_drive), .reg_rdata(reg_rdata),
      .data_code(data_code), .mod_pattern(mod_pattern),
      .ready_pulse_n(ready_pulse_n), .ready_pulse_oe_n(ready_pulse_oe_n),
      .sdo(sdo), .sdo_oe_n(sdo_oe_n));

   arp_host_model arp_host_model_inst (.ext_run(ext_run),
      .mode_req(mode_req), .mod_level(mod_level),
      .ext_clk_pin(ext_clk_pin), .oscillator_pin_two(oscillator_pin_two),
      .mod_bits(mod_bits));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task results;
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task wr(input logic [4:0] a, input logic [23:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [4:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      q = reg_rdata;
   endtask : rd

   task wp(output int n);
      n = 0;
      while (ready_pulse_n !== 1'b0 && n < 40000)
      begin
         @(negedge ref_clk);
         n++;
      end
      while (ready_pulse_n === 1'b0)
         @(negedge ref_clk);
   endtask : wp

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      wr(arp_pkg::ADR_PHASE, 24'h000123);
      @(negedge ref_clk);
      chk("rst_code", 24'h000000, data_code);
      chk("rst_comp", 24'h000003, {20'h00000, mod_pattern});
      chk("rst_oe", 24'h000003, {22'h0, ready_pulse_oe_n, sdo_oe_n});
   endtask : t_reset

   task t_regs;
      rd(arp_pkg::ADR_PHASE);
      chk("phase_rst", 24'h000000, q);
      rd(arp_pkg::ADR_CONFIG);
      chk("cfg_rst", 24'h000003, q);
      rd(arp_pkg::ADR_STATUS);
      chk("st_rst", 24'h000003, q);
      wr(arp_pkg::ADR_STATUS, 24'h000002);
      rd(arp_pkg::ADR_STATUS);
      chk("st_ro", 24'h000003, q);
      rd(5'h1f);
      chk("unmapped", 24'h000000, q);
      wp(n0);
      rd(arp_pkg::ADR_STATUS);
      chk("st_set", 24'h000002, q);
      rd(arp_pkg::ADR_STATUS);
      chk("st_clr", 24'h000003, q);
      wp(n0);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= arp_pkg::ADR_STATUS;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("st_b2b_set", 24'h000002, reg_rdata);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk("st_b2b_clr", 24'h000003, reg_rdata);
      @(posedge ref_clk);
      sdo_drive <= 1'b1;
      sdo_data <= 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("sdo_pins", 24'h000002, {22'h0, sdo, sdo_oe_n});
   endtask : t_regs

   task t_phase;
      wr(arp_pkg::ADR_CONFIG, 24'h000007);
      wr(arp_pkg::ADR_PHASE, 24'h000800);
      wp(n0);
      wr(arp_pkg::ADR_PHASE, 24'h000000);
      wp(n1);
      chk("delay_span", 24'h000001,
         {23'h0, ((n1 - n0 - 8192) inside {[-4:4]})});
      wr(arp_pkg::ADR_CONFIG, 24'h000047);
      wr(arp_pkg::ADR_PHASE, 24'h000800);
      wp(n2);
      chk("gain_lat", 24'h000001,
         {23'h0, ((n2 - n0 - 96) inside {[-4:4]})});
   endtask : t_phase

   task t_cal;
      wr(arp_pkg::ADR_OFFSET, 24'h123456);
      wr(arp_pkg::ADR_CONFIG, 24'h000020);
      wp(n0);
      wp(n0);
      chk("off_code", 24'h123400, data_code);
      @(posedge ref_clk);
      mod_level <= 4'h7;
      wr(arp_pkg::ADR_OFFSET, 24'h7fffff);
      wp(n0);
      wp(n0);
      chk("sat_hi", 24'h7fffff, data_code);
      @(posedge ref_clk);
      mod_level <= 4'h0;
      wr(arp_pkg::ADR_GAIN, 24'h400000);
      wr(arp_pkg::ADR_OFFSET, 24'h100000);
      wr(arp_pkg::ADR_CONFIG, 24'h000060);
      repeat (3) wp(n0);
      chk("gain_code", 24'h180000, data_code);
      wr(arp_pkg::ADR_CONFIG, 24'h000000);
      rd(arp_pkg::ADR_GAIN);
      chk("gain_kept", 24'h400000, q);
      rd(arp_pkg::ADR_OFFSET);
      chk("off_kept", 24'h100000, q);
   endtask : t_cal

   task t_two;
      @(posedge ref_clk);
      ext_run <= 1'b1;
      mode_req <= 1'b1;
      wr(arp_pkg::ADR_CONFIG, 24'h0000a0);
      repeat (3) wp(n0);
      chk("two_wire", 24'h000000, data_code);
      chk("ext_rate", 24'h000001, {23'h0, (n0 inside {[300:320]})});
      @(posedge ref_clk);
      shutdown <= 1'b1;
      n1 = 0;
      repeat (400)
      begin
         @(negedge ref_clk);
         if (ready_pulse_n !== 1'b1)
            n1++;
      end
      chk("shutdown", 24'h000000, 24'(n1));
      @(posedge ref_clk);
      shutdown <= 1'b0;
   endtask : t_two

   task t_rst2;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      wr(arp_pkg::ADR_GAIN, 24'h000055);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(arp_pkg::ADR_OFFSET);
      chk("off_rst2", 24'h000000, q);
      rd(arp_pkg::ADR_GAIN);
      chk("gain_rst2", 24'h000000, q);
      rd(arp_pkg::ADR_STATUS);
      chk("st_rst2", 24'h000003, q);
   endtask : t_rst2

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         results();
      end
   end

   initial
   begin
      rst_n = 1'b0;
      shutdown = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 24'h000000;
      sdo_data = 1'b0;
      sdo_drive = 1'b0;
      ext_run = 1'b0;
      mode_req = 1'b0;
      mod_level = 4'h0;
      repeat (2) @(posedge ref_clk);
      t_reset;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs;
      t_phase;
      t_cal;
      t_two;
      t_rst2;
      results();
   end
endmodule : tb_top
